// >>> hw/iosr_pkg.sv
// package for the i/o sample reporter: widths, codes, timing constants
// assumes a 125 MHz clock and byte-wide record output
package iosr_pkg;
  localparam int unsigned DIG_LINES     = 13;
  localparam int unsigned ANA_CHANS     = 6;
  localparam int unsigned ADC_W         = 16;
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_S;
  localparam logic [7:0]  SAMPLE_SETS   = 8'h01;
  localparam logic [7:0]  FIELD_SEP     = 8'h0D;
  localparam logic [7:0]  ERR_CODE      = 8'hEE;
  localparam logic [2:0]  PIN_ANALOG    = 3'h2;
  localparam logic [2:0]  PIN_DIG_MON   = 3'h3;
  localparam logic [2:0]  PIN_DIG_UNMON = 3'h0;

  typedef enum logic [1:0] {
    IOSR_SRC_QUERY,
    IOSR_SRC_PERIOD,
    IOSR_SRC_CHANGE
  } iosr_src_t;

  // record byte stream towards the serial or radio path
  typedef struct packed {
    logic       valid;
    logic       last;
    logic       err;
    logic       remote;
    logic [7:0] data;
  } iosr_byte_t;

  typedef struct packed {
    logic [31:0] high;
    logic [31:0] low;
  } iosr_dest_t;
endpackage

// >>> hw/iosr_ms_timer.sv
// millisecond period timer for periodic sampling
// assumes the clock rate given in the package
`timescale 1ns/1ps
module iosr_ms_timer #(
  parameter int unsigned CYC_PER_MS = iosr_pkg::CYC_PER_MS
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_restart,
  input  wire logic [15:0] i_period_ms,
  output logic             o_tick
);
  logic [31:0] cyc_reg;
  logic [31:0] cyc_next;
  logic [15:0] ms_reg;
  logic [15:0] ms_next;
  logic        tick_next;

  always_comb begin
    cyc_next  = cyc_reg;
    ms_next   = ms_reg;
    tick_next = 1'b0;
    if (i_restart || i_period_ms == 16'h0000) begin
      cyc_next = 32'h0000_0000;
      ms_next  = 16'h0000;
    end else if (cyc_reg == CYC_PER_MS - 1) begin
      cyc_next = 32'h0000_0000;
      if (ms_reg + 16'h0001 >= i_period_ms) begin
        ms_next   = 16'h0000;
        tick_next = 1'b1;
      end else begin
        ms_next = ms_reg + 16'h0001;
      end
    end else begin
      cyc_next = cyc_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cyc_reg <= 32'h0000_0000;
      ms_reg  <= 16'h0000;
      o_tick  <= 1'b0;
    end else begin
      cyc_reg <= cyc_next;
      ms_reg  <= ms_next;
      o_tick  <= tick_next;
    end
  end
endmodule

// >>> hw/iosr_reporter.sv
// i/o sample reporter: builds sample records from digital lines and adc
// values and streams them byte by byte
// assumes pins, configs and adc values are synchronous to i_clk
//
// Behaviour
// - query with no digital or analog input configured answers an error
// - first record field is the sample set count, always one
// - digital mask bits 0..12 map lines 0..12, set when enabled
// - analog mask bits 0..5 map channels 0..5, set when enabled
// - two-byte digital state word only when some digital line enabled
// - two bytes per enabled analog channel, ascending, disabled skipped
// - command-mode query returns fields separated by carriage returns
// - period zero gives no periodic samples
// - nonzero period samples every that many ms, sent to remote
// - transmitted records address destination from high and low settings
// - received records forwarded only in framed host mode, else dropped
// - no sample data without at least one input pin configured
// - when sleeping enabled, periodic samples only until wake hold expires
// - edge on a change-mask line configured as digital input triggers an immediate record
// - change detection works only while awake
// - periodic sampling produces a sample upon waking
// - pin config two makes an analog-capable pin an analog input
`timescale 1ns/1ps
module iosr_reporter #(
  parameter int unsigned DIG_LINES  = iosr_pkg::DIG_LINES,
  parameter int unsigned ANA_CHANS  = iosr_pkg::ANA_CHANS,
  parameter int unsigned CYC_PER_MS = iosr_pkg::CYC_PER_MS
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic [DIG_LINES*3-1:0]   i_pin_cfg,
  input  wire logic [DIG_LINES-1:0]     i_dig_in,
  input  wire logic [ANA_CHANS*16-1:0]  i_adc,
  input  wire logic                     i_query_inputs_cmd,
  input  wire logic                     i_cmd_mode,
  input  wire logic [15:0]              i_sample_period_ms,
  input  wire logic [DIG_LINES-1:0]     i_change_mask,
  input  wire logic [31:0]              i_dest_addr_high,
  input  wire logic [31:0]              i_dest_addr_low,
  input  wire logic                     i_sleep_en,
  input  wire logic                     i_awake,
  input  wire logic                     i_wake_hold_done,
  input  wire logic                     i_framed_host_mode,
  input  wire iosr_pkg::iosr_byte_t     i_rx_rec,
  input  wire logic                     i_out_ready,
  output iosr_pkg::iosr_byte_t          o_rec,
  output iosr_pkg::iosr_dest_t          o_dest,
  output logic                          o_busy,
  output iosr_pkg::iosr_byte_t          o_host_rec
);
  // ==========================================================
  // configuration decode
  function automatic logic is_dig(input logic [2:0] c);
    is_dig = (c == iosr_pkg::PIN_DIG_UNMON) ||
             (c == iosr_pkg::PIN_DIG_MON);
  endfunction

  logic [DIG_LINES-1:0] dig_mask;
  logic [ANA_CHANS-1:0] ana_mask;
  always_comb begin
    for (int i = 0; i < DIG_LINES; i++)
      dig_mask[i] = is_dig(i_pin_cfg[i*3 +: 3]);
    for (int i = 0; i < ANA_CHANS; i++)
      ana_mask[i] = (i_pin_cfg[i*3 +: 3] == iosr_pkg::PIN_ANALOG);
  end
  wire any_in = (|dig_mask) || (|ana_mask);

  // ==========================================================
  // triggers
  typedef enum {
    FLD_IDLE,
    FLD_ERR,
    FLD_SETS,
    FLD_DMASK_H,
    FLD_DMASK_L,
    FLD_AMASK,
    FLD_DIG_H,
    FLD_DIG_L,
    FLD_ANA_H,
    FLD_ANA_L
  } iosr_state_t;

  iosr_state_t          fld_reg;
  iosr_state_t          fld_next;
  logic [DIG_LINES-1:0] prev_reg;
  logic                 awake_reg;
  logic                 pend_q_reg;
  logic                 pend_q_next;
  logic                 pend_t_reg;
  logic                 pend_t_next;
  logic                 tick;

  wire woke   = i_awake && !awake_reg;
  wire period_ok = (i_sample_period_ms != 16'h0000) &&
                   (!i_sleep_en || (i_awake && !i_wake_hold_done));
  wire change = i_awake &&
                (|((i_dig_in ^ prev_reg) & i_change_mask & dig_mask));
  wire wake_smp = woke && i_sleep_en &&
                  (i_sample_period_ms != 16'h0000);

  iosr_ms_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_timer (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_restart   (woke),
    .i_period_ms (i_sample_period_ms),
    .o_tick      (tick)
  );

  // ==========================================================
  // record builder
  iosr_pkg::iosr_byte_t rec_reg;
  iosr_pkg::iosr_byte_t rec_next;
  logic [DIG_LINES-1:0] dsnap_reg;
  logic [DIG_LINES-1:0] dsnap_next;
  logic [ANA_CHANS*16-1:0] asnap_reg;
  logic [ANA_CHANS*16-1:0] asnap_next;
  logic [ANA_CHANS-1:0] arem_reg;
  logic [ANA_CHANS-1:0] arem_next;
  logic [2:0]           ch_reg;
  logic [2:0]           ch_next;
  logic                 cmd_reg;
  logic                 cmd_next;
  logic                 sep_reg;
  logic                 sep_next;
  // digital mask frozen with the data, so a config change mid-record
  // cannot split mask and state word
  logic [DIG_LINES-1:0] dmsk_reg;
  logic [DIG_LINES-1:0] dmsk_next;

  function automatic logic [2:0] low_set(input logic [ANA_CHANS-1:0] m);
    low_set = 3'h0;
    for (int i = ANA_CHANS - 1; i >= 0; i--)
      if (m[i]) low_set = i[2:0];
  endfunction

  // next field after the analog mask byte, skipping absent fields
  function automatic iosr_state_t after_amask(
    input logic [DIG_LINES-1:0] d, input logic [ANA_CHANS-1:0] a);
    if (|d) after_amask = FLD_DIG_H;
    else if (|a) after_amask = FLD_ANA_H;
    else after_amask = FLD_IDLE;
  endfunction

  wire [DIG_LINES-1:0] dig_now = i_dig_in & dig_mask;
  wire [15:0] dword = 16'(dsnap_reg);
  wire [15:0] aword = asnap_reg[ch_reg*16 +: 16];
  wire [15:0] dmw   = 16'(dmsk_reg);
  wire        adv   = !rec_reg.valid || i_out_ready;

  always_comb begin
    fld_next    = fld_reg;
    dmsk_next   = dmsk_reg;
    rec_next    = rec_reg;
    dsnap_next  = dsnap_reg;
    asnap_next  = asnap_reg;
    arem_next   = arem_reg;
    ch_next     = ch_reg;
    cmd_next    = cmd_reg;
    sep_next    = sep_reg;
    pend_q_next = pend_q_reg || i_query_inputs_cmd;
    pend_t_next = pend_t_reg || (tick && period_ok) || change || wake_smp;
    if (rec_reg.valid && i_out_ready)
      rec_next.valid = 1'b0;
    if (adv) begin
      // separator bytes between fields in command mode
      if (sep_reg && fld_reg != FLD_IDLE) begin
        rec_next.valid = 1'b1;
        rec_next.last  = 1'b0;
        rec_next.data  = iosr_pkg::FIELD_SEP;
        sep_next       = 1'b0;
      end else begin
        case (fld_reg)
          FLD_IDLE: begin
            if (pend_q_reg) begin
              pend_q_next = i_query_inputs_cmd;
              cmd_next    = i_cmd_mode;
              rec_next.remote = 1'b0;
              fld_next = any_in ? FLD_SETS : FLD_ERR;
            end else if (pend_t_reg) begin
              pend_t_next = (tick && period_ok) || change || wake_smp;
              cmd_next    = 1'b0;
              rec_next.remote = 1'b1;
              if (any_in) fld_next = FLD_SETS;
            end
            dsnap_next = dig_now;
            asnap_next = i_adc;
            arem_next  = ana_mask;
            dmsk_next  = dig_mask;
          end
          FLD_ERR: begin
            rec_next = '{valid: 1'b1, last: 1'b1, err: 1'b1,
                         remote: 1'b0, data: iosr_pkg::ERR_CODE};
            fld_next = FLD_IDLE;
          end
          FLD_SETS: begin
            rec_next.valid = 1'b1;
            rec_next.last  = 1'b0;
            rec_next.err   = 1'b0;
            rec_next.data  = iosr_pkg::SAMPLE_SETS;
            sep_next = cmd_reg;
            fld_next = FLD_DMASK_H;
          end
          FLD_DMASK_H: begin
            rec_next.valid = 1'b1;
            rec_next.data  = dmw[15:8];
            fld_next = FLD_DMASK_L;
          end
          FLD_DMASK_L: begin
            rec_next.valid = 1'b1;
            rec_next.data  = dmw[7:0];
            sep_next = cmd_reg;
            fld_next = FLD_AMASK;
          end
          FLD_AMASK: begin
            rec_next.valid = 1'b1;
            rec_next.data  = 8'(arem_reg);
            fld_next = after_amask(dmsk_reg, arem_reg);
            rec_next.last = (fld_next == FLD_IDLE);
            sep_next = cmd_reg && (fld_next != FLD_IDLE);
            ch_next  = low_set(arem_reg);
          end
          FLD_DIG_H: begin
            rec_next.valid = 1'b1;
            rec_next.data  = dword[15:8];
            fld_next = FLD_DIG_L;
          end
          FLD_DIG_L: begin
            rec_next.valid = 1'b1;
            rec_next.data  = dword[7:0];
            fld_next = (|arem_reg) ? FLD_ANA_H : FLD_IDLE;
            rec_next.last = ~(|arem_reg);
            sep_next = cmd_reg && (|arem_reg);
          end
          FLD_ANA_H: begin
            rec_next.valid = 1'b1;
            rec_next.data  = aword[15:8];
            arem_next[ch_reg] = 1'b0;
            fld_next = FLD_ANA_L;
          end
          FLD_ANA_L: begin
            rec_next.valid = 1'b1;
            rec_next.data  = aword[7:0];
            ch_next = low_set(arem_reg);
            fld_next = (|arem_reg) ? FLD_ANA_H : FLD_IDLE;
            rec_next.last = ~(|arem_reg);
            sep_next = cmd_reg && (|arem_reg);
          end
          default: fld_next = FLD_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fld_reg    <= FLD_IDLE;
      dmsk_reg   <= '0;
      rec_reg    <= '0;
      dsnap_reg  <= '0;
      asnap_reg  <= '0;
      arem_reg   <= '0;
      ch_reg     <= 3'h0;
      cmd_reg    <= 1'b0;
      sep_reg    <= 1'b0;
      pend_q_reg <= 1'b0;
      pend_t_reg <= 1'b0;
      // present levels, so release of reset shows no false edge
      prev_reg   <= i_dig_in;
      awake_reg  <= 1'b0;
    end else begin
      fld_reg    <= fld_next;
      dmsk_reg   <= dmsk_next;
      rec_reg    <= rec_next;
      dsnap_reg  <= dsnap_next;
      asnap_reg  <= asnap_next;
      arem_reg   <= arem_next;
      ch_reg     <= ch_next;
      cmd_reg    <= cmd_next;
      sep_reg    <= sep_next;
      pend_q_reg <= pend_q_next;
      pend_t_reg <= pend_t_next;
      // while asleep the lines are tracked so wake sees no stale edge
      prev_reg   <= i_dig_in;
      awake_reg  <= i_awake;
    end
  end

  // ==========================================================
  // destination and received-record forwarding
  iosr_pkg::iosr_dest_t dest_reg;
  iosr_pkg::iosr_byte_t host_reg;
  iosr_pkg::iosr_byte_t host_next;
  always_comb begin
    host_next       = i_rx_rec;
    host_next.valid = i_rx_rec.valid && i_framed_host_mode;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dest_reg <= '0;
      host_reg <= '0;
    end else begin
      dest_reg <= '{high: i_dest_addr_high, low: i_dest_addr_low};
      host_reg <= host_next;
    end
  end

  assign o_rec      = rec_reg;
  assign o_dest     = dest_reg;
  assign o_busy     = (fld_reg != FLD_IDLE) || rec_reg.valid;
  assign o_host_rec = host_reg;
endmodule

// >>> testbench/iosr_sink.sv
// sink model standing behind the record output of the reporter
// assumes stall requests from the bench are synchronous to i_clk
`timescale 1ns/1ps
module iosr_sink (
  input  wire logic                 i_clk,
  input  wire logic                 i_stall,
  input  wire iosr_pkg::iosr_byte_t i_rec,
  output logic                      o_ready
);
  // ==========================================================
  // accept and log bytes
  // ready is registered, so a stall shows one cycle late, as a real sink
  iosr_pkg::iosr_byte_t q[$];
  int                   n_rem = 0;
  always @(posedge i_clk) begin
    if (i_rec.valid && o_ready) begin
      q.push_back(i_rec);
      if (i_rec.last)
        n_rem += int'(i_rec.remote);
    end
    o_ready <= !i_stall;
  end
endmodule

// >>> testbench/iosr_chk.sv
// concurrent checks on the reporter's ports
// assumes it is bound into every reporter instance
`timescale 1ns/1ps
module iosr_chk (
  input wire logic                 i_clk,
  input wire logic                 i_rst,
  input wire logic                 i_query_inputs_cmd,
  input wire logic [31:0]          i_dest_addr_high,
  input wire logic [31:0]          i_dest_addr_low,
  input wire logic                 i_framed_host_mode,
  input wire iosr_pkg::iosr_byte_t i_rx_rec,
  input wire logic                 i_out_ready,
  input wire iosr_pkg::iosr_byte_t o_rec,
  input wire iosr_pkg::iosr_dest_t o_dest,
  input wire logic                 o_busy,
  input wire iosr_pkg::iosr_byte_t o_host_rec
);
  // ==========================================================
  // first-byte tracker
  logic first_reg;
  logic first_next;
  always_comb begin
    first_next = first_reg;
    if (o_rec.valid && i_out_ready)
      first_next = o_rec.last;
  end
  always_ff @(posedge i_clk)
    first_reg <= i_rst ? 1'b1 : first_next;
  // ==========================================================
  // properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_host_drop: assert property (!i_framed_host_mode |=>
    !o_host_rec.valid) else $error("host record passed while transparent");
  chk_host_data: assert property (i_framed_host_mode && i_rx_rec.valid
    |=> o_host_rec == $past(i_rx_rec)) else $error("host record differs");
  chk_dest_addr: assert property (1'b1 |=>
    o_dest == $past({i_dest_addr_high, i_dest_addr_low}))
    else $error("destination does not follow settings");
  chk_byte_hold: assert property (o_rec.valid && !i_out_ready
    |=> $stable(o_rec)) else $error("record byte changed while stalled");
  chk_query_answer: assert property (i_query_inputs_cmd && !o_busy
    |-> ##[1:4] o_rec.valid) else $error("query got no answer");
  chk_sets_first: assert property (o_rec.valid && first_reg && !o_rec.err
    |-> o_rec.data == iosr_pkg::SAMPLE_SETS) else $error("bad first byte");
  chk_err_byte: assert property (o_rec.valid && o_rec.err |->
    o_rec.last && !o_rec.remote && o_rec.data == iosr_pkg::ERR_CODE)
    else $error("malformed error answer");
  chk_mask_follows: assert property (o_rec.valid && first_reg
    |-> !o_rec.last || o_rec.err) else $error("record ends after one byte");
endmodule

bind iosr_reporter iosr_chk u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_query_inputs_cmd(i_query_inputs_cmd),
  .i_dest_addr_high(i_dest_addr_high), .i_dest_addr_low(i_dest_addr_low),
  .i_framed_host_mode(i_framed_host_mode), .i_rx_rec(i_rx_rec),
  .i_out_ready(i_out_ready), .o_rec(o_rec), .o_dest(o_dest),
  .o_busy(o_busy), .o_host_rec(o_host_rec)
);

// >>> testbench/io_sample_reporter_test.sv
// self-checking bench for the i/o sample reporter
// assumes the sink model and the bound checker sit beside the dut
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("[ERR] %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module io_sample_reporter_test;
  // ==========================================================
  // wiring
  // a short millisecond keeps periodic scenarios within a few hundred cycles
  localparam int unsigned CPM = 40;
  logic                 clk;
  logic                 rst, query, cmd_mode, slp, awake, hold;
  logic                 framed = 1'b0;
  logic [38:0]          pin_cfg;
  logic [12:0]          dig_in, chg;
  logic [95:0]          adc;
  logic [15:0]          period;
  logic [31:0]          dst_hi, dst_lo, bg;
  logic                 stall = 1'b1;
  logic                 ready, busy;
  iosr_pkg::iosr_byte_t rx, rec, host;
  iosr_pkg::iosr_dest_t dest;
  logic [31:0]          lfsr_reg = 32'h0001_8076;
  logic [7:0]           eq[$], em[$];
  logic [2:0]           cfg_tab[4] = '{3'h0, 3'h2, 3'h3, 3'h4};
  int                   fails = 0;
  int                   n_tests = 0;
  iosr_reporter #(.CYC_PER_MS(CPM)) dut (
    .i_clk(clk), .i_rst(rst), .i_pin_cfg(pin_cfg), .i_dig_in(dig_in),
    .i_adc(adc), .i_query_inputs_cmd(query), .i_cmd_mode(cmd_mode),
    .i_sample_period_ms(period), .i_change_mask(chg),
    .i_dest_addr_high(dst_hi), .i_dest_addr_low(dst_lo), .i_sleep_en(slp),
    .i_awake(awake), .i_wake_hold_done(hold), .i_framed_host_mode(framed),
    .i_rx_rec(rx), .i_out_ready(ready), .o_rec(rec), .o_dest(dest),
    .o_busy(busy), .o_host_rec(host));
  iosr_sink sink (.i_clk(clk), .i_stall(stall), .i_rec(rec), .o_ready(ready));
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    lfsr_reg = {lfsr_reg[30:0],
                lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
    return lfsr_reg;
  endfunction
  task automatic put(input logic [7:0] b, input logic [7:0] m, input bit s);
    if (s) begin
      eq.push_back(b);
      em.push_back(m);
    end
  endtask
  task automatic exp_build(input logic cmd);
    logic [15:0] dm;
    logic [7:0]  am;
    logic [15:0] w;
    bit          first;
    dm = '0;
    am = '0;
    first = 1'b1;
    for (int n = 0; n < 13; n++) begin
      dm[n] = pin_cfg[3*n+:3] inside {3'h0, 3'h3};
      if (n < 6)
        am[n] = pin_cfg[3*n+:3] == 3'h2;
    end
    eq.delete();
    em.delete();
    put(iosr_pkg::ERR_CODE, 8'hFF, dm == '0 && am == '0);
    if (dm == '0 && am == '0)
      return;
    put(8'h01, 8'hFF, 1'b1);
    put(iosr_pkg::FIELD_SEP, 8'hFF, cmd);
    put(dm[15:8], 8'hFF, 1'b1);
    put(dm[7:0], 8'hFF, 1'b1);
    put(iosr_pkg::FIELD_SEP, 8'hFF, cmd);
    put(am, 8'hFF, 1'b1);
    put(iosr_pkg::FIELD_SEP, 8'hFF, cmd);
    w = {3'b000, dig_in};
    put(w[15:8], dm[15:8], dm != '0);
    put(w[7:0], dm[7:0], dm != '0);
    put(iosr_pkg::FIELD_SEP, 8'hFF, cmd && dm != '0);
    for (int c = 0; c < 6; c++) begin
      put(iosr_pkg::FIELD_SEP, 8'hFF, cmd && am[c] && !first);
      put(adc[16*c+8+:8], 8'hFF, am[c]);
      put(adc[16*c+:8], 8'hFF, am[c]);
      first = first && !am[c];
    end
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic run_query(input logic cmd);
    int                   k;
    iosr_pkg::iosr_byte_t b;
    exp_build(cmd);
    sink.q.delete();
    cmd_mode <= cmd;
    query <= 1'b1;
    @(posedge clk);
    query <= 1'b0;
    for (k = 0; k < 400 && sink.q.size() < eq.size(); k++)
      @(posedge clk);
    if (k >= 400) begin
      fails++;
      tally_and_finish();
    end
    repeat (4) @(posedge clk);
    `CHK("rec_len", eq.size(), sink.q.size())
    if (eq.size() == sink.q.size())
      foreach (eq[i]) begin
        b = sink.q[i];
        `CHK("rec_data", eq[i] & em[i], b.data & em[i])
        `CHK("rec_last", i == eq.size() - 1, b.last)
        `CHK("rec_local", 1'b0, b.remote)
      end
  endtask
  task automatic watch(input string nm, input int cyc, lo, hi);
    int n0;
    n0 = sink.n_rem;
    repeat (cyc) @(posedge clk);
    `CHK(nm, 1'b1, sink.n_rem - n0 >= lo && sink.n_rem - n0 <= hi)
  endtask
  // ==========================================================
  // clock, background traffic and scenarios
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    bg = rnd();
    stall <= bg[0] & bg[1];
    rx <= bg[15:4];
    framed <= bg[20] ? bg[21] : framed;
    dst_hi <= bg;
    dst_lo <= ~bg;
  end
  initial begin
    logic [31:0] r;
    logic [2:0]  c;
    logic [38:0] cv;
    logic        cmd;
    {rst, query, cmd_mode, slp, awake, hold} = 6'h20;
    {pin_cfg, dig_in, chg, adc, period} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    awake <= 1'b1;
    for (int t = 0; t < 16; t++) begin
      for (int n = 0; n < 13; n++) begin
        r = rnd();
        c = cfg_tab[r[1:0]];
        if (t < 3)
          c = (t == 2 && n < 6) ? 3'h2 : (t == 1 ? 3'h3 : 3'h4);
        cv[3*n+:3] = (c == 3'h2 && n >= 6) ? 3'h4 : c;
      end
      cmd = t == 3 || (t > 3 && r[5]);
      if (cmd)
        cv[2:0] = 3'h2;
      pin_cfg <= cv;
      dig_in <= r[24:12];
      adc <= {rnd(), rnd(), rnd()};
      @(posedge clk);
      run_query(cmd);
    end
    pin_cfg <= {13{3'h3}};
    watch("no_period", 400, 0, 0);
    period <= 16'h0002;
    watch("periodic", 800, 9, 11);
    pin_cfg <= {13{3'h4}};
    repeat (40) @(posedge clk);
    watch("no_inputs", 400, 0, 0);
    pin_cfg <= {13{3'h3}};
    slp <= 1'b1;
    awake <= 1'b0;
    repeat (40) @(posedge clk);
    watch("asleep", 400, 0, 0);
    awake <= 1'b1;
    watch("wake", 40, 1, 1);
    hold <= 1'b1;
    watch("hold_done", 400, 0, 0);
    {slp, hold} <= 2'b00;
    period <= 16'h0000;
    chg <= 13'h0010;
    repeat (40) @(posedge clk);
    dig_in <= dig_in ^ 13'h0080;
    watch("unmasked", 40, 0, 0);
    dig_in <= dig_in ^ 13'h0010;
    watch("change", 40, 1, 1);
    awake <= 1'b0;
    @(posedge clk);
    dig_in <= dig_in ^ 13'h0010;
    watch("asleep_chg", 40, 0, 0);
    tally_and_finish();
  end
endmodule
